// ==== rtl/repeat_area_pkg.sv ====
package repeat_area_pkg;
  // ==========================================================================
  // field layout of the address control register
  localparam int SRC_AREA_MSB = 12;
  localparam int SRC_AREA_LSB = 8;
  localparam int SRC_IRQ_EN_BIT = 15;
  localparam int DST_IRQ_EN_BIT = 7;
  localparam int DST_AREA_MSB = 4;
  localparam int DST_AREA_LSB = 0;
  localparam int AREA_SEL_W = 5;
  // ==========================================================================
  // area codes and reset values
  localparam logic [4:0] AREA_NONE = 5'h00;
  localparam logic [4:0] AREA_MIN = 5'h02;
  localparam logic [4:0] AREA_MAX = 5'h1B;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ==========================================================================
  // address update modes
  typedef enum logic [1:0] {
    UPD_FIXED = 2'b00,
    UPD_OFFSET = 2'b01,
    UPD_INC = 2'b10,
    UPD_DEC = 2'b11
  } upd_mode_t;
endpackage

// ==== rtl/dma_extended_repeat_area.sv ====
// Overview of operation
// (RULE1) source area select field occupies bits 12 down to 8
// (RULE2) inside an area only the selected low address bits change
// (RULE3) area sizes are powers of two, four bytes to 128 Mbytes; the code does not check AREA_MIN or AREA_MAX, so code 1 gives two bytes
// (RULE4) overflow wraps to area start on increment, area end on decrement
// (RULE5) source overflow requests interrupt only when source enable is 1
// (RULE6) destination overflow interrupt enable is read/write bit 7
// (RULE7) destination overflow with enable clears transfer enable, sets flag
// (RULE8) in block mode the interrupt waits until the block completes
// (RULE9) setting transfer enable again resumes from the stopped state
// (RULE10) destination enable ignored when no destination area selected
// (RULE11) code 0 means no area; code n selects lowest n bits
// (RULE12) source overflow with enable clears transfer enable, sets flag
// (RULE13) destination area select field occupies bits 4 down to 0
// (RULE14) interrupt request follows the overflow flag
module dma_extended_repeat_area
  import repeat_area_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ctrl_we,
  input wire logic [15:0] ctrl_wdata,
  output logic [15:0] ctrl_rdata,
  input wire logic enable_set,
  input wire logic enable_clr,
  input wire logic flag_clr,
  input wire logic block_mode,
  input wire logic block_end,
  input wire logic src_load,
  input wire logic [ADDR_W-1:0] src_load_value,
  input wire logic dst_load,
  input wire logic [ADDR_W-1:0] dst_load_value,
  input wire logic src_step,
  input wire logic [1:0] src_mode,
  input wire logic dst_step,
  input wire logic [1:0] dst_mode,
  input wire logic [ADDR_W-1:0] src_offset,
  input wire logic [ADDR_W-1:0] dst_offset,
  input wire logic [2:0] access_bytes,
  output logic [ADDR_W-1:0] source_address_reg,
  output logic [ADDR_W-1:0] destination_address_reg,
  output logic channel_transfer_enable,
  output logic repeat_overflow_irq_flag,
  output logic channel_irq
);

  // the widest area needs 28 address bits; masks are built in at most 32 bits
  if (ADDR_W < 28 || ADDR_W > 32) begin : g_width_check
    $error("ADDR_W must be 28 to 32");
  end

  // ==========================================================================
  // helpers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic ovf;
  } step_t;

  function automatic logic area_on(input logic [4:0] code);
    return code != AREA_NONE; // RULE11
  endfunction

  function automatic logic [ADDR_W-1:0] area_mask(input logic [4:0] code);
    logic [ADDR_W-1:0] m;
    m = '0;
    if (area_on(code)) begin // RULE11
      m = (ADDR_W'(1) << code) - ADDR_W'(1); // RULE3
    end
    return m;
  endfunction

  function automatic step_t addr_step(input logic [ADDR_W-1:0] cur, input upd_mode_t mode,
                                      input logic [ADDR_W-1:0] ofs, input logic [2:0] size,
                                      input logic [4:0] code);
    logic [ADDR_W-1:0] m;
    logic [ADDR_W-1:0] raw;
    step_t r;
    m = area_mask(code);
    case (mode)
      UPD_OFFSET: raw = cur + ofs;
      UPD_INC: raw = cur + ADDR_W'(size);
      UPD_DEC: raw = cur - ADDR_W'(size);
      default: raw = cur;
    endcase
    r.ovf = 1'b0;
    r.addr = raw;
    if (area_on(code)) begin
      r.addr = (cur & ~m) | (raw & m); // RULE2
      r.ovf = (raw & ~m) != (cur & ~m);
      if (r.ovf && mode == UPD_DEC) begin
        r.addr = cur | m; // RULE4
      end else if (r.ovf) begin
        r.addr = cur & ~m; // RULE4
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // control fields
  logic [4:0] src_area_sel;
  logic [4:0] dst_area_sel;
  logic src_overflow_irq_en;
  logic dst_overflow_irq_en;
  logic [4:0] next_src_area_sel;
  logic [4:0] next_dst_area_sel;
  logic next_src_overflow_irq_en;
  logic next_dst_overflow_irq_en;
  logic [15:0] next_ctrl_rdata;

  always_comb begin
    next_src_area_sel = src_area_sel;
    next_dst_area_sel = dst_area_sel;
    next_src_overflow_irq_en = src_overflow_irq_en;
    next_dst_overflow_irq_en = dst_overflow_irq_en;
    if (ctrl_we) begin
      next_src_area_sel = ctrl_wdata[SRC_AREA_MSB:SRC_AREA_LSB]; // RULE1
      next_dst_area_sel = ctrl_wdata[DST_AREA_MSB:DST_AREA_LSB]; // RULE13
      next_src_overflow_irq_en = ctrl_wdata[SRC_IRQ_EN_BIT];
      next_dst_overflow_irq_en = ctrl_wdata[DST_IRQ_EN_BIT]; // RULE6
    end
    next_ctrl_rdata = '0;
    next_ctrl_rdata[SRC_AREA_MSB:SRC_AREA_LSB] = next_src_area_sel;
    next_ctrl_rdata[DST_AREA_MSB:DST_AREA_LSB] = next_dst_area_sel;
    next_ctrl_rdata[SRC_IRQ_EN_BIT] = next_src_overflow_irq_en;
    next_ctrl_rdata[DST_IRQ_EN_BIT] = next_dst_overflow_irq_en;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      src_area_sel <= AREA_NONE;
      dst_area_sel <= AREA_NONE;
      src_overflow_irq_en <= 1'b0;
      dst_overflow_irq_en <= 1'b0;
      ctrl_rdata <= CTRL_RESET[15:0];
    end else begin
      src_area_sel <= next_src_area_sel;
      dst_area_sel <= next_dst_area_sel;
      src_overflow_irq_en <= next_src_overflow_irq_en;
      dst_overflow_irq_en <= next_dst_overflow_irq_en;
      ctrl_rdata <= next_ctrl_rdata;
    end
  end

  // ==========================================================================
  // address step results
  step_t src_res;
  step_t dst_res;
  logic src_advance;
  logic dst_advance;

  always_comb begin
    src_res = addr_step(source_address_reg, upd_mode_t'(src_mode), src_offset, access_bytes, src_area_sel);
    dst_res = addr_step(destination_address_reg, upd_mode_t'(dst_mode), dst_offset, access_bytes, dst_area_sel);
    // stepping is held while the channel is stopped so a resume continues in place
    // a loading cycle takes the load value and never flags an overflow
    src_advance = src_step && channel_transfer_enable && !src_load; // RULE9
    dst_advance = dst_step && channel_transfer_enable && !dst_load; // RULE9
  end

  // ==========================================================================
  // source address register
  logic [ADDR_W-1:0] next_src_addr;

  always_comb begin
    next_src_addr = source_address_reg;
    if (src_load) begin
      next_src_addr = src_load_value;
    end else if (src_advance) begin
      next_src_addr = src_res.addr; // RULE2
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      source_address_reg <= ADDR_RESET[ADDR_W-1:0];
    end else begin
      source_address_reg <= next_src_addr;
    end
  end

  // ==========================================================================
  // destination address register
  logic [ADDR_W-1:0] next_dst_addr;

  always_comb begin
    next_dst_addr = destination_address_reg;
    if (dst_load) begin
      next_dst_addr = dst_load_value;
    end else if (dst_advance) begin
      next_dst_addr = dst_res.addr; // RULE2
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      destination_address_reg <= ADDR_RESET[ADDR_W-1:0];
    end else begin
      destination_address_reg <= next_dst_addr;
    end
  end

  // ==========================================================================
  // overflow events
  logic src_ovf_event;
  logic dst_ovf_event;
  logic ovf_event;

  always_comb begin
    // an overflow with its side's enable at 0 only wraps
    src_ovf_event = 1'b0;
    dst_ovf_event = 1'b0;
    if (src_advance && src_res.ovf && src_overflow_irq_en) begin
      src_ovf_event = 1'b1; // RULE5 RULE12
    end
    if (dst_advance && dst_res.ovf && dst_overflow_irq_en) begin
      if (area_on(dst_area_sel)) begin // RULE10
        dst_ovf_event = 1'b1; // RULE7
      end
    end
    ovf_event = src_ovf_event || dst_ovf_event;
  end

  // ==========================================================================
  // block mode deferral
  logic pending;
  logic next_pending;
  logic stop_now;

  always_comb begin
    // inside a block the stop waits for the block's last transfer
    next_pending = pending;
    stop_now = 1'b0;
    if (block_mode) begin
      if ((pending || ovf_event) && block_end) begin // RULE8
        stop_now = 1'b1;
        next_pending = 1'b0;
      end else if (ovf_event) begin
        next_pending = 1'b1; // RULE8
      end
    end else begin
      stop_now = ovf_event || pending;
      next_pending = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pending <= 1'b0;
    end else begin
      pending <= next_pending;
    end
  end

  // ==========================================================================
  // transfer enable
  logic next_enable;

  always_comb begin
    // clear wins over set, and an overflow stop wins over both
    next_enable = channel_transfer_enable;
    if (enable_clr) begin
      next_enable = 1'b0;
    end else if (enable_set) begin
      next_enable = 1'b1; // RULE9
    end
    if (stop_now) begin
      next_enable = 1'b0; // RULE7 RULE12
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      channel_transfer_enable <= 1'b0;
    end else begin
      channel_transfer_enable <= next_enable;
    end
  end

  // ==========================================================================
  // overflow flag and interrupt request
  logic next_flag;
  logic next_irq;

  always_comb begin
    next_flag = repeat_overflow_irq_flag;
    if (flag_clr) begin
      next_flag = 1'b0;
    end
    // a stop in the clearing cycle wins so no overflow is lost
    if (stop_now) begin
      next_flag = 1'b1; // RULE7 RULE12
    end
    next_irq = next_flag; // RULE14
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      repeat_overflow_irq_flag <= 1'b0;
      channel_irq <= 1'b0;
    end else begin
      repeat_overflow_irq_flag <= next_flag;
      channel_irq <= next_irq;
    end
  end

endmodule

// ==== test/repeat_area_properties.sv ====
module repeat_area_props #(parameter int ADDR_W = 32) (
  input logic sys_clk,
  input logic rst,
  input logic ctrl_we,
  input logic [15:0] ctrl_wdata,
  input logic [15:0] ctrl_rdata,
  input logic enable_set,
  input logic enable_clr,
  input logic block_mode,
  input logic block_end,
  input logic src_load,
  input logic src_step,
  input logic [ADDR_W-1:0] source_address_reg,
  input logic channel_transfer_enable,
  input logic repeat_overflow_irq_flag,
  input logic channel_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_stopped;
    !channel_transfer_enable && channel_irq;
  endsequence
  AST_RESET: assert property (disable iff (1'b0) rst |=> !channel_transfer_enable && !channel_irq)
    else $error("outputs not cleared by reset");
  AST_CTRL: assert property (ctrl_we |=> ctrl_rdata == ($past(ctrl_wdata) & 16'h9F9F))
    else $error("field readback wrong");
  AST_IRQ: assert property (channel_irq == repeat_overflow_irq_flag)
    else $error("irq differs from flag");
  AST_STOP: assert property ($rose(repeat_overflow_irq_flag) |-> s_stopped)
    else $error("overflow without stop");
  AST_EN: assert property ($rose(repeat_overflow_irq_flag) |-> $past(ctrl_rdata[15] || ctrl_rdata[7]))
    else $error("flag set with irq disabled");
  AST_BLOCK: assert property ($rose(repeat_overflow_irq_flag) && $past(block_mode) |-> $past(block_end))
    else $error("block stop before block end");
  AST_UPPER: assert property (src_step && channel_transfer_enable && !src_load && !ctrl_we && ctrl_rdata[12:8] != 5'h00
    |=> (source_address_reg >> $past(ctrl_rdata[12:8])) == $past(source_address_reg >> ctrl_rdata[12:8]))
    else $error("upper address bits changed");
  AST_HOLD: assert property (!channel_transfer_enable && !src_load |=> $stable(source_address_reg))
    else $error("address moved while stopped");
  AST_SET: assert property (enable_set && !enable_clr && !channel_transfer_enable |=> channel_transfer_enable)
    else $error("enable not set");
  AST_CLR: assert property (enable_clr |=> !channel_transfer_enable)
    else $error("enable not cleared");
endmodule
bind dma_extended_repeat_area repeat_area_props #(.ADDR_W(ADDR_W)) repeat_area_props_inst (.sys_clk, .rst,
  .ctrl_we, .ctrl_wdata, .ctrl_rdata, .enable_set, .enable_clr, .block_mode, .block_end, .src_load, .src_step,
  .source_address_reg, .channel_transfer_enable, .repeat_overflow_irq_flag, .channel_irq);

// ==== test/test_dma_extended_repeat_area.sv ====
module test_dma_extended_repeat_area;
  timeunit 1ns;
  timeprecision 1ns;
  import repeat_area_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, ctrl_we = 1'b0, enable_set = 1'b0, enable_clr = 1'b0, flag_clr = 1'b0;
  logic block_mode = 1'b0, block_end = 1'b0, src_load = 1'b0, dst_load = 1'b0, src_step = 1'b0, dst_step = 1'b0;
  logic [15:0] ctrl_wdata = 16'h0000, ctrl_rdata;
  logic [1:0] src_mode = 2'h0, dst_mode = 2'h0;
  logic [31:0] src_v = 32'h0, dst_v = 32'h0, src_a, dst_a;
  logic en, flag, irq;
  wire logic [31:0] st = {29'h0, en, flag, irq};
  int fails = 0, cmp_count = 0;
  localparam logic [8:0] P_WE = 9'h100, P_SET = 9'h080, P_CLR = 9'h040, P_FCL = 9'h020, P_BE = 9'h010;
  localparam logic [8:0] P_SLD = 9'h008, P_DLD = 9'h004, P_SST = 9'h002, P_DST = 9'h001;
  always #20 sys_clk = ~sys_clk;
  dma_extended_repeat_area dma_extended_repeat_area_inst (.sys_clk, .rst, .ctrl_we, .ctrl_wdata, .ctrl_rdata,
    .enable_set, .enable_clr, .flag_clr, .block_mode, .block_end, .src_load, .src_load_value(src_v), .dst_load,
    .dst_load_value(dst_v), .src_step, .src_mode, .dst_step, .dst_mode, .src_offset(32'h0000_0010),
    .dst_offset(32'h0000_0010), .access_bytes(3'h4), .source_address_reg(src_a), .destination_address_reg(dst_a),
    .channel_transfer_enable(en), .repeat_overflow_irq_flag(flag), .channel_irq(irq));
  // ==========================================================================
  // access tasks
  task automatic pulse(input logic [8:0] p, input logic [1:0] m, input logic [31:0] v);
    @(posedge sys_clk);
    {ctrl_we, enable_set, enable_clr, flag_clr, block_end, src_load, dst_load, src_step, dst_step} <= p;
    src_mode <= m;
    dst_mode <= m;
    src_v <= v;
    dst_v <= v;
    ctrl_wdata <= v[15:0];
    @(posedge sys_clk);
    {ctrl_we, enable_set, enable_clr, flag_clr, block_end, src_load, dst_load, src_step, dst_step} <= 9'h000;
    @(negedge sys_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d fails=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================================================
  // tests
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk(st | {16'h0000, ctrl_rdata}, 32'h0);
    pulse(P_WE, 2'h0, 32'hFFFF);
    chk({16'h0000, ctrl_rdata}, 32'h9F9F);
    pulse(P_WE, 2'h0, 32'h8400);
    pulse(P_SLD | P_SET, 2'h0, 32'h100);
    repeat (3) pulse(P_SST, 2'h2, 32'h0);
    chk(src_a, 32'h10C);
    pulse(P_SST, 2'h2, 32'h0);
    chk(src_a, 32'h100);
    chk(st, 32'h3);
    pulse(P_SST, 2'h2, 32'h0);
    chk(src_a, 32'h100);
    pulse(P_SET | P_FCL, 2'h0, 32'h0);
    pulse(P_SST, 2'h2, 32'h0);
    chk(src_a, 32'h104);
    pulse(P_WE, 2'h0, 32'h1B00);
    pulse(P_SLD, 2'h0, 32'h07FF_FFFC);
    pulse(P_SST, 2'h2, 32'h0);
    chk(src_a, 32'h0);
    chk(st, 32'h4);
    pulse(P_WE | P_DLD, 2'h0, 32'h2003);
    pulse(P_DST, 2'h3, 32'h0);
    chk(dst_a, 32'h2007);
    pulse(P_WE | P_DLD, 2'h0, 32'h2080);
    pulse(P_DST, 2'h2, 32'h0);
    chk(dst_a, 32'h2084);
    chk(st, 32'h4);
    @(posedge sys_clk) block_mode <= 1'b1;
    pulse(P_WE | P_DLD, 2'h0, 32'h0082);
    pulse(P_DST, 2'h2, 32'h0);
    chk(dst_a, 32'h80);
    chk(st, 32'h4);
    pulse(P_BE, 2'h0, 32'h0);
    chk(st, 32'h3);
    @(posedge sys_clk) block_mode <= 1'b0;
    pulse(P_SET | P_FCL, 2'h0, 32'h0);
    pulse(P_DST, 2'h2, 32'h0);
    chk(st, 32'h3);
    pulse(P_CLR, 2'h0, 32'h0);
    chk(st, 32'h3 & 32'h3);
    pulse(P_SET | P_FCL, 2'h0, 32'h0);
    pulse(P_DST, 2'h1, 32'h0);
    chk(dst_a, 32'h80);
    chk(st, 32'h3);
    pulse(P_SET | P_FCL, 2'h0, 32'h0);
    pulse(P_DST, 2'h0, 32'h0);
    chk(dst_a, 32'h80);
    pulse(P_CLR, 2'h0, 32'h0);
    chk(st, 32'h0);
    print_verdict();
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    print_verdict();
  end
endmodule
